//--- msi_app_model.sv
`timescale 1ns/1ns
`default_nettype none
module msi_app_model (
  input  wire logic       clk,
  input  wire logic       grant,
  output logic            req,
  output logic [2:0]      tc,
  output logic [4:0]      vec
);
  initial begin
    req = 1'b0;
    tc  = 3'h0;
    vec = 5'h00;
  end

  task automatic send(input logic [2:0] t, input logic [4:0] v);
    @(posedge clk);
    req <= 1'b1;
    tc  <= t;
    vec <= v;
    @(posedge clk);
    while (grant !== 1'b1) @(posedge clk);
    // Junk on idle lines so a late sample shows up
    req <= 1'b0;
    tc  <= ~t;
    vec <= ~v;
    @(posedge clk);
  endtask : send
endmodule : msi_app_model
`default_nettype wire

//--- msi_message_former.sv
`timescale 1ns/1ns
`default_nettype none
module msi_message_former (
  input  wire msi_request_pkg::msi_csr_t   csr,
  input  wire logic [2:0]                  traffic_class,
  input  wire logic [4:0]                  vector,
  input  wire logic [31:0]                 addr_lo,
  input  wire logic [31:0]                 addr_hi,
  input  wire logic [15:0]                 data_base,
  output msi_request_pkg::mem_write_t      pkt,
  output logic                             vector_ok
);
  import msi_request_pkg::*;

  logic [4:0] alloc_mask;

  always_comb begin
    unique case (csr.alloc_count)
      COUNT_1:  alloc_mask = 5'h00;
      COUNT_2:  alloc_mask = 5'h01;
      COUNT_4:  alloc_mask = 5'h03;
      COUNT_8:  alloc_mask = 5'h07;
      COUNT_16: alloc_mask = 5'h0F;
      COUNT_32: alloc_mask = 5'h1F;
      // Reserved codes fall back to one message
      default:  alloc_mask = 5'h00;
    endcase
  end

  always_comb begin
    vector_ok          = (vector & ~alloc_mask) == 5'h00;
    pkt.traffic_class  = traffic_class;
    pkt.addr64         = csr.addr64_capable;
    pkt.addr           = csr.addr64_capable ? {addr_hi, addr_lo[31:2], 2'h0}
                                            : {32'h0000_0000, addr_lo[31:2], 2'h0};
    pkt.data           = 16'(data_base + {11'h000, vector & alloc_mask});
  end

endmodule : msi_message_former
`default_nettype wire

//--- msi_request_interface.sv
// Our own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module msi_request_interface (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic [31:0]                      hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic                        msi_request_in,
  input  wire logic [2:0]                  msi_traffic_class_in,
  input  wire logic [4:0]                  msi_vector_in,
  output logic                             msi_grant,
  output msi_request_pkg::msi_csr_t        msi_csr_out,
  output logic                             tlp_valid,
  input  wire logic                        tlp_ready,
  output msi_request_pkg::mem_write_t      tlp_pkt,
  output logic                             irq
);
  import msi_request_pkg::*;

  logic                 pend;
  logic                 pend_write;
  logic [7:0]           pend_addr;
  logic                 commit;
  logic [31:0]          read_mux;
  logic [31:0]          addr_lo;
  logic [31:0]          addr_hi;
  logic [15:0]          data_base;
  logic [EV_COUNT-1:0]  irq_status;
  logic [EV_COUNT-1:0]  irq_mask;
  logic [EV_COUNT-1:0]  ev_set;
  logic [EV_COUNT-1:0]  ev_clr;
  engine_state_t        state;
  mem_write_t           formed;
  logic                 vector_ok;
  logic [2:0]           hsize_q;

  msi_message_former u_former (
    .csr           (msi_csr_out),
    .traffic_class (msi_traffic_class_in),
    .vector        (msi_vector_in),
    .addr_lo       (addr_lo),
    .addr_hi       (addr_hi),
    .data_base     (data_base),
    .pkt           (formed),
    .vector_ok     (vector_ok)
  );

  // Every transfer takes one wait state, so reads always see committed writes
  always_ff @(posedge clk) begin
    if (rst) begin
      pend       <= 1'b0;
      pend_write <= 1'b0;
      pend_addr  <= 8'h00;
      hreadyout  <= 1'b1;
      hrdata     <= 32'h0000_0000;
    end else if (pend) begin
      pend      <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= pend_write ? 32'h0000_0000 : read_mux;
    end else if (hsel && htrans[1] && hready) begin
      pend       <= 1'b1;
      hreadyout  <= 1'b0;
      pend_addr  <= haddr[7:0];
      pend_write <= hwrite;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Only whole-word writes take effect
  assign commit = pend && pend_write && (hsize_q == SIZE_WORD);

  always_ff @(posedge clk) begin
    if (rst) begin
      hsize_q <= SIZE_WORD;
    end else if (!pend && hsel && htrans[1] && hready) begin
      hsize_q <= hsize;
    end
  end

  always_comb begin
    unique case (pend_addr)
      OFS_CONFIG:     read_mux = {16'h0000, msi_csr_out};
      OFS_VIEW:       read_mux = {16'h0000, msi_csr_out};
      OFS_ADDR_LO:    read_mux = addr_lo;
      OFS_ADDR_HI:    read_mux = addr_hi;
      OFS_DATA_BASE:  read_mux = {16'h0000, data_base};
      OFS_IRQ_STATUS: read_mux = {29'h0000_0000, irq_status};
      OFS_IRQ_MASK:   read_mux = {29'h0000_0000, irq_mask};
      OFS_ENGINE:     read_mux = {28'h000_0000, tlp_valid, msi_grant, 2'(state)};
      default:        read_mux = 32'h0000_0000;
    endcase
  end

  // view fields written by software, reserved bits held at zero
  always_ff @(posedge clk) begin
    if (rst) begin
      msi_csr_out <= msi_csr_t'(CONFIG_RESET);
    end else if (commit && pend_addr == OFS_CONFIG) begin
      msi_csr_out <= msi_csr_t'(hwdata[15:0] & CONFIG_WMASK);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_lo   <= ADDR_RESET;
      addr_hi   <= ADDR_RESET;
      data_base <= DATA_RESET;
    end else if (commit) begin
      if (pend_addr == OFS_ADDR_LO) begin
        addr_lo <= hwdata;
      end
      if (pend_addr == OFS_ADDR_HI) begin
        addr_hi <= hwdata;
      end
      if (pend_addr == OFS_DATA_BASE) begin
        data_base <= hwdata[15:0];
      end
    end
  end

  always_comb begin
    ev_set              = '0;
    ev_set[EV_SENT]     = (state == ST_SEND) && tlp_ready;
    ev_set[EV_REFUSED]  = (state == ST_IDLE) && msi_request_in && !msi_csr_out.enable;
    ev_set[EV_RANGE]    = (state == ST_IDLE) && msi_request_in && msi_csr_out.enable
                          && !vector_ok;
    ev_clr              = (commit && pend_addr == OFS_IRQ_STATUS)
                          ? hwdata[EV_COUNT-1:0] : '0;
  end

  // Set beats a simultaneous write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask <= '0;
    end else if (commit && pend_addr == OFS_IRQ_MASK) begin
      irq_mask <= hwdata[EV_COUNT-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // Packet is frozen at acceptance so a late change of inputs cannot tear it
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      tlp_valid <= 1'b0;
      tlp_pkt   <= '0;
      msi_grant <= 1'b0;
    end else begin
      msi_grant <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (msi_request_in && msi_csr_out.enable) begin
            tlp_pkt   <= formed;
            tlp_valid <= 1'b1;
            state     <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tlp_ready) begin
            tlp_valid <= 1'b0;
            msi_grant <= 1'b1;
            state     <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          if (!msi_request_in) begin
            state <= ST_IDLE;
          end
        end
        // Spare state code drops any packet and goes back to idle
        default: begin
          tlp_valid <= 1'b0;
          state     <= ST_IDLE;
        end
      endcase
    end
  end

  a_grant_not_early: assert property (@(posedge clk) disable iff (rst)
    $rose(msi_grant) |-> $past(msi_request_in) && $past(msi_request_in, 2))
    else $error("grant came too soon after request");

  a_grant_one_pulse: assert property (@(posedge clk) disable iff (rst)
    msi_grant |=> !msi_grant)
    else $error("grant longer than one cycle");

  a_grant_on_accept: assert property (@(posedge clk) disable iff (rst)
    tlp_valid && tlp_ready |=> msi_grant && !tlp_valid)
    else $error("accepted packet not granted");

  a_no_send_disabled: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) |-> $past(msi_csr_out.enable) && $past(msi_request_in))
    else $error("packet started while disabled");

  a_class_carried: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) |-> tlp_pkt.traffic_class == $past(msi_traffic_class_in))
    else $error("traffic class not carried");

  a_offset_full_32: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_32
    |-> tlp_pkt.data == 16'($past(data_base) + {11'h000, $past(msi_vector_in)}))
    else $error("message data not base plus offset");

  a_offset_eight: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_8
    |-> tlp_pkt.data == 16'($past(data_base) + {13'h0000, $past(msi_vector_in[2:0])}))
    else $error("eight message code misread");

  a_packet_held: assert property (@(posedge clk) disable iff (rst)
    tlp_valid && !tlp_ready |=> tlp_valid && $stable(tlp_pkt))
    else $error("packet dropped or changed before acceptance");

  a_addr32_upper: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && !$past(msi_csr_out.addr64_capable)
    |-> tlp_pkt.addr[63:32] == 32'h0000_0000 && !tlp_pkt.addr64)
    else $error("upper address sent while 32-bit only");

  a_view_written: assert property (@(posedge clk) disable iff (rst)
    commit && pend_addr == OFS_CONFIG
    |=> msi_csr_out[8:0] == $past(hwdata[8:0]) && msi_csr_out[15:9] == 7'h00)
    else $error("view fields do not follow the write");

  a_count_fields: assert property (@(posedge clk) disable iff (rst)
    $rose(hreadyout) && !$past(pend_write) && $past(pend_addr) == OFS_VIEW
    |-> hrdata[6:1] == {msi_csr_out.alloc_count, msi_csr_out.request_count})
    else $error("count fields misreported");

  a_grant_needs_request: assert property (@(posedge clk) disable iff (rst)
    msi_grant |-> $past(msi_request_in) && $past(state) == ST_SEND)
    else $error("grant without a pending request");

  a_offset_one: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_1
    |-> tlp_pkt.data == $past(data_base))
    else $error("one message data not base");

  a_offset_two: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_2
    |-> tlp_pkt.data == 16'($past(data_base) + {15'h0000, $past(msi_vector_in[0])}))
    else $error("two message code misread");

  a_offset_four: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_4
    |-> tlp_pkt.data == 16'($past(data_base) + {14'h0000, $past(msi_vector_in[1:0])}))
    else $error("four message code misread");

  a_offset_sixteen: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count) == COUNT_16
    |-> tlp_pkt.data == 16'($past(data_base) + {12'h000, $past(msi_vector_in[3:0])}))
    else $error("sixteen message code misread");

  a_count_reserved: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.alloc_count[2:1]) == 2'h3
    |-> tlp_pkt.data == $past(data_base))
    else $error("reserved count not treated as one message");

  a_addr64_full: assert property (@(posedge clk) disable iff (rst)
    $rose(tlp_valid) && $past(msi_csr_out.addr64_capable)
    |-> tlp_pkt.addr64 && tlp_pkt.addr == {$past(addr_hi), $past(addr_lo[31:2]), 2'h0})
    else $error("full address not sent while capable");

  a_refused_flag: assert property (@(posedge clk) disable iff (rst)
    state == ST_IDLE && msi_request_in && !msi_csr_out.enable |=> irq_status[EV_REFUSED])
    else $error("request while disabled not flagged");

  a_sent_flag: assert property (@(posedge clk) disable iff (rst)
    tlp_valid && tlp_ready |=> irq_status[EV_SENT])
    else $error("accepted packet not flagged");

  a_capability_read: assert property (@(posedge clk) disable iff (rst)
    $rose(hreadyout) && !$past(pend_write) && $past(pend_addr) == OFS_VIEW
    |-> hrdata[8:7] == {msi_csr_out.vector_mask_capable, msi_csr_out.addr64_capable})
    else $error("capability bits misreported");

  a_enable_read: assert property (@(posedge clk) disable iff (rst)
    $rose(hreadyout) && !$past(pend_write) && $past(pend_addr) == OFS_VIEW
    |-> hrdata[0] == msi_csr_out.enable)
    else $error("enable bit misreported");

endmodule : msi_request_interface
`default_nettype wire

//--- msi_request_pkg.sv
// Behaviour
// - The block raises the grant output to acknowledge that it has taken a pending request.
// - Each request carries a 3-bit traffic class, and the interrupt goes out in that class.
// - Each request carries a 5-bit vector offset that is added to the base message data.
// - Each interrupt leaves as a memory write packet on the link side.
// - Bit 8 of the exported control/status view reads 1 when per-vector masking is supported.
// - Bit 7 of the view reads 1 when a 64-bit message address can be sent, else 0.
// - Bits 6 to 4 of the view give the allocated count, and codes 110 and 111 are reserved.
// - Bits 3 to 1 of the view give the requested count that system software reads.
// - While bit 0 of the view is clear, no request is made and no interrupt is sent; a request made anyway is refused and flagged in EV_REFUSED.
// - A grant comes two clock cycles after the request at the earliest, never sooner.
package msi_request_pkg;

  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_VIEW       = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO    = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI    = 8'h0C;
  localparam logic [7:0] OFS_DATA_BASE  = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;
  localparam logic [7:0] OFS_ENGINE     = 8'h1C;

  localparam logic [2:0]  SIZE_WORD     = 3'h2;
  localparam logic [15:0] CONFIG_RESET  = 16'h0000;
  localparam logic [15:0] CONFIG_WMASK  = 16'h01FF;
  localparam logic [31:0] ADDR_RESET    = 32'h0000_0000;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  // Event bit positions in status and mask
  localparam int EV_SENT     = 0;
  localparam int EV_REFUSED  = 1;
  localparam int EV_RANGE    = 2;
  localparam int EV_COUNT    = 3;

  localparam logic [2:0] COUNT_1  = 3'h0;
  localparam logic [2:0] COUNT_2  = 3'h1;
  localparam logic [2:0] COUNT_4  = 3'h2;
  localparam logic [2:0] COUNT_8  = 3'h3;
  localparam logic [2:0] COUNT_16 = 3'h4;
  localparam logic [2:0] COUNT_32 = 3'h5;

  typedef struct packed {
    logic [6:0] reserved;
    logic       vector_mask_capable;
    logic       addr64_capable;
    logic [2:0] alloc_count;
    logic [2:0] request_count;
    logic       enable;
  } msi_csr_t;

  typedef struct packed {
    logic [2:0]  traffic_class;
    logic        addr64;
    logic [63:0] addr;
    logic [15:0] data;
  } mem_write_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_RELEASE
  } engine_state_t;

endpackage : msi_request_pkg

//--- tb_msi_request_interface.sv
`timescale 1ns/1ns
`default_nettype none
module tb_msi_request_interface;
  import msi_request_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, addr_lo, addr_hi, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tc, code, t;
  logic [4:0]  vec, v;
  logic        req, msi_grant, tlp_valid, tlp_ready, irq, grant_due;
  msi_csr_t    csr;
  mem_write_t  pkt;
  logic [15:0] base, cfg;
  logic [18:0] expq[$];
  logic [18:0] got;
  int          n_fail, checks, n;

  msi_request_interface i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .msi_request_in(req),
    .msi_traffic_class_in(tc), .msi_vector_in(vec), .msi_grant(msi_grant),
    .msi_csr_out(csr), .tlp_valid(tlp_valid), .tlp_ready(tlp_ready), .tlp_pkt(pkt),
    .irq(irq));
  msi_app_model i_app (.clk(clk), .grant(msi_grant), .req(req), .tc(tc), .vec(vec));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, e);
  endtask : rd_chk

  task automatic report_and_stop();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Link stalls at random
  always @(posedge clk) tlp_ready <= ($urandom % 3) != 0;

  always @(posedge clk) begin
    if (rst) begin
      grant_due <= 1'b0;
    end else begin
      chk({31'h0, msi_grant}, {31'h0, grant_due});
      grant_due <= tlp_valid && tlp_ready;
      if (tlp_valid && tlp_ready) begin
        got = (expq.size() != 0) ? expq.pop_front() : 19'h7FFFF;
        chk({13'h0, pkt.traffic_class, pkt.data}, {13'h0, got});
        chk(pkt.addr[31:0], {addr_lo[31:2], 2'b00});
        chk(pkt.addr[63:32], cfg[7] ? addr_hi : 32'h0);
        chk({31'h0, pkt.addr64}, {31'h0, cfg[7]});
      end
    end
  end

  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; n_fail = 0; checks = 0;
    void'($urandom(28));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({16'h0, csr}, 32'h0);
    rd_chk(OFS_CONFIG, 32'h0);
    bus(1'b1, OFS_VIEW, 32'hFFFF, r);
    rd_chk(OFS_VIEW, 32'h0);
    rd_chk(8'h20, 32'h0);
    addr_lo = $urandom;
    bus(1'b1, OFS_ADDR_LO, addr_lo, r);
    addr_hi = $urandom;
    bus(1'b1, OFS_ADDR_HI, addr_hi, r);
    base = 16'($urandom);
    bus(1'b1, OFS_DATA_BASE, {16'h0, base}, r);
    bus(1'b1, OFS_IRQ_MASK, 32'h2, r);
    expq.push_back({3'h5, base});
    fork
      i_app.send(3'h5, 5'h00);
    join_none
    repeat (12) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'h2);
    for (int i = 0; i < 8; i++) begin
      code = 3'(i);
      // Reserved codes grant a single message
      n = (i < 6) ? (1 << i) : 1;
      r = $urandom;
      cfg = {7'h00, r[1:0], code, r[4:2], 1'b1};
      bus(1'b1, OFS_CONFIG, {16'h0, cfg}, r);
      wait fork;
      @(posedge clk);
      chk({16'h0, csr}, {16'h0, cfg});
      rd_chk(OFS_VIEW, {16'h0, cfg});
      repeat (3) begin
        v = 5'($urandom % n);
        t = 3'($urandom);
        expq.push_back({t, base + {11'h0, v}});
        i_app.send(t, v);
      end
    end
    bus(1'b1, OFS_IRQ_STATUS, 32'h2, r);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, OFS_IRQ_STATUS, 32'h1, r);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    bus(1'b1, OFS_CONFIG, 32'h0, r);
    @(posedge clk);
    chk({16'h0, csr}, 32'h0);
    chk(expq.size(), 32'h0);
    report_and_stop();
  end
endmodule : tb_msi_request_interface
`default_nettype wire
